// ===== design/coac_pkg.sv
package coac_pkg;
    // ============================================================
    // timing
    // ============================================================
    localparam int CLK_FREQ_HZ     = 125_000_000;
    localparam int WINDOW_US       = 1000;
    localparam int WINDOW_CYCLES   = (CLK_FREQ_HZ / 1_000_000) * WINDOW_US;
    localparam int WIN_CNT_W       = 17;

    // ============================================================
    // object attributes and commands
    // ============================================================
    localparam logic [15:0] CTRL_OBJ_INDEX   = 16'h6040;
    localparam int          FAULT_RESET_BIT  = 7;
    localparam int          SIZE_W           = 3;
    localparam int          ALARM_W          = 8;

    // alarm vector positions
    localparam int ALM_SDO_OVF   = 0;
    localparam int ALM_PDO_OVF   = 1;
    localparam int ALM_SUBIDX    = 2;
    localparam int ALM_SIZE      = 3;
    localparam int ALM_RDONLY    = 4;
    localparam int ALM_NOPDO     = 5;
    localparam int ALM_RUNPROT   = 6;
    localparam int ALM_INDEX     = 7;

    typedef enum logic [1:0] {
        COAC_WIN_IDLE = 2'b00,
        COAC_WIN_OPEN = 2'b01
    } coac_win_t;
endpackage : coac_pkg

// ===== design/coac_rate_win.sv
`timescale 1ns/100ps
`default_nettype none
// flags every further arrival inside a fixed window opened by the first one
module coac_rate_win
    import coac_pkg::*;
#(
    parameter int WIN_CYCLES = WINDOW_CYCLES
) (
    input  wire logic sys_clk,   // system clock
    input  wire logic rst,       // async reset, high
    input  wire logic msg_in,    // one-cycle arrival pulse
    output logic      ovf_pulse  // second arrival inside window
);
    coac_win_t             state_r;
    logic [WIN_CNT_W-1:0]  cnt_r;
    localparam logic [WIN_CNT_W-1:0] LAST = WIN_CNT_W'(WIN_CYCLES - 1);
    localparam logic [WIN_CNT_W-1:0] ONE  = WIN_CNT_W'(1);

    // ============================================================
    // window state
    // ============================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= COAC_WIN_IDLE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                COAC_WIN_IDLE: begin
                    if (msg_in) begin
                        state_r <= COAC_WIN_OPEN;
                        cnt_r   <= '0;
                    end
                end
                COAC_WIN_OPEN: begin
                    if (cnt_r == LAST) begin
                        // an arrival exactly at expiry starts a fresh window
                        state_r <= msg_in ? COAC_WIN_OPEN : COAC_WIN_IDLE;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + ONE;
                    end
                end
                default: begin
                    state_r <= COAC_WIN_IDLE;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    assign ovf_pulse = msg_in && (state_r == COAC_WIN_OPEN) && (cnt_r != LAST);
endmodule : coac_rate_win
`default_nettype wire

// ===== design/coac_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
module coac_checker
    import coac_pkg::*;
#(
    parameter int WIN_CYCLES = WINDOW_CYCLES
) (
    input  wire logic              sys_clk,        // system clock
    input  wire logic              rst,            // async reset, high
    input  wire logic              sdo_rx,         // sdo message taken, pulse
    input  wire logic              pdo_rx,         // pdo message taken, pulse
    input  wire logic              pdo_is_write,   // pdo access writes object
    input  wire logic              pdo_map_req,    // access asks pdo mapping
    input  wire logic [15:0]       pdo_index,      // object index addressed
    input  wire logic              obj_found,      // index exists in dictionary
    input  wire logic              subidx_found,   // sub-index exists
    input  wire logic [SIZE_W-1:0] msg_len,        // data bytes in message
    input  wire logic [SIZE_W-1:0] obj_len,        // defined object size
    input  wire logic              obj_read_only,  // object read-only
    input  wire logic              obj_pdo_ok,     // object mappable to pdo
    input  wire logic              obj_run_prot,   // protected while enabled
    input  wire logic              drive_enabled,  // drive in enabled state
    input  wire logic              nmt_reset_node, // nmt node reset, pulse
    input  wire logic              ctrl_wr,        // sdo write to control object
    input  wire logic [15:0]       ctrl_index,     // index of that write
    input  wire logic [15:0]       ctrl_data,      // controlword written
    output logic [ALARM_W-1:0]     alarm_r,        // sticky alarm flags
    output logic                   alarm_any_r,    // any alarm raised
    output logic                   write_ok_r,     // pdo write accepted, pulse
    output logic                   write_rej_r     // pdo write refused, pulse
);
    logic                 sdo_ovf;
    logic                 pdo_ovf;
    logic                 clear_req;
    logic                 fr_prev_r;
    logic                 fr_bit;
    logic [ALARM_W-1:0]   ev_nxt;
    logic                 refuse;
    logic [ALARM_W-1:0]   alarm_nxt;
    logic [WIN_CNT_W-1:0] sdo_gap_r;
    logic [WIN_CNT_W-1:0] pdo_gap_r;

    localparam logic [WIN_CNT_W-1:0] GAP_SAT = WIN_CNT_W'(WIN_CYCLES);
    localparam logic [WIN_CNT_W-1:0] GAP_ONE = WIN_CNT_W'(1);

    // one decode shared by the edge detector and its history register
    function automatic logic ctrl_hit(input logic wr, input logic [15:0] idx);
        return wr && (idx == CTRL_OBJ_INDEX);
    endfunction : ctrl_hit

    // ============================================================
    // arrival rate windows
    // ============================================================
    coac_rate_win #(.WIN_CYCLES(WIN_CYCLES)) u_sdo_win (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .msg_in    (sdo_rx),
        .ovf_pulse (sdo_ovf)
    );
    coac_rate_win #(.WIN_CYCLES(WIN_CYCLES)) u_pdo_win (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .msg_in    (pdo_rx),
        .ovf_pulse (pdo_ovf)
    );

    // ============================================================
    // access checks
    // ============================================================
    always_comb begin
        ev_nxt = '0;
        ev_nxt[ALM_SDO_OVF] = sdo_ovf;
        ev_nxt[ALM_PDO_OVF] = pdo_ovf;
        if (pdo_rx) begin
            // index missing masks the finer checks, nothing else is known
            ev_nxt[ALM_INDEX]   = !obj_found;
            ev_nxt[ALM_SUBIDX]  = obj_found && !subidx_found;
            ev_nxt[ALM_SIZE]    = obj_found && subidx_found && (msg_len != obj_len);
            ev_nxt[ALM_RDONLY]  = obj_found && pdo_is_write && obj_read_only;
            ev_nxt[ALM_NOPDO]   = obj_found && pdo_map_req && !obj_pdo_ok;
            ev_nxt[ALM_RUNPROT] = obj_found && pdo_is_write && drive_enabled
                                  && obj_run_prot;
        end
    end

    assign refuse = |ev_nxt[ALARM_W-1:ALM_SUBIDX];

    // ============================================================
    // clear on node reset or fault-reset rising edge
    // ============================================================
    assign fr_bit    = ctrl_hit(ctrl_wr, ctrl_index) && ctrl_data[FAULT_RESET_BIT];
    assign clear_req = nmt_reset_node || (fr_bit && !fr_prev_r);
    // set beats clear: an event in the clearing cycle survives it
    assign alarm_nxt = (clear_req ? '0 : alarm_r) | ev_nxt;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fr_prev_r <= 1'b0;
        end else if (ctrl_hit(ctrl_wr, ctrl_index)) begin
            fr_prev_r <= ctrl_data[FAULT_RESET_BIT];
        end
    end

    // ============================================================
    // sticky alarms, set beats clear
    // ============================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            alarm_r     <= '0;
            alarm_any_r <= 1'b0;
        end else begin
            alarm_r     <= alarm_nxt;
            alarm_any_r <= |alarm_nxt;
        end
    end

    // ============================================================
    // write verdict
    // ============================================================
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            write_ok_r  <= 1'b0;
            write_rej_r <= 1'b0;
        end else begin
            write_ok_r  <= pdo_rx && pdo_is_write && !refuse;
            write_rej_r <= pdo_rx && pdo_is_write && refuse;
        end
    end

    // ============================================================
    // assertions
    // ============================================================
    // cycles since the last arrival, saturating at one window; read only by the
    // assertions, so the window length is checked against a count of its own
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sdo_gap_r <= GAP_SAT;
        end else if (sdo_rx) begin
            sdo_gap_r <= GAP_ONE;
        end else if (sdo_gap_r != GAP_SAT) begin
            sdo_gap_r <= sdo_gap_r + GAP_ONE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pdo_gap_r <= GAP_SAT;
        end else if (pdo_rx) begin
            pdo_gap_r <= GAP_ONE;
        end else if (pdo_gap_r != GAP_SAT) begin
            pdo_gap_r <= pdo_gap_r + GAP_ONE;
        end
    end

    a_sdo_ovf_set: assert property (@(posedge sys_clk) disable iff (rst)
        sdo_rx ##1 (!sdo_rx)[*3] ##1 sdo_rx |=> alarm_r[ALM_SDO_OVF])
        else $error("sdo overflow not flagged");
    a_sdo_gap_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        sdo_rx && (sdo_gap_r == GAP_SAT) && !alarm_r[ALM_SDO_OVF] |=> !alarm_r[ALM_SDO_OVF])
        else $error("sdo overflow after a full window");
    a_sdo_ovf_cause: assert property (@(posedge sys_clk) disable iff (rst)
        !sdo_rx && !alarm_r[ALM_SDO_OVF] |=> !alarm_r[ALM_SDO_OVF])
        else $error("sdo overflow without arrival");
    a_pdo_ovf_set: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx ##1 pdo_rx |=> alarm_r[ALM_PDO_OVF])
        else $error("pdo overflow not flagged");
    a_pdo_gap_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && (pdo_gap_r == GAP_SAT) && !alarm_r[ALM_PDO_OVF] |=> !alarm_r[ALM_PDO_OVF])
        else $error("pdo overflow after a full window");
    a_pdo_ovf_cause: assert property (@(posedge sys_clk) disable iff (rst)
        !pdo_rx && !alarm_r[ALM_PDO_OVF] |=> !alarm_r[ALM_PDO_OVF])
        else $error("pdo overflow without arrival");
    a_subidx_alarm: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && obj_found && !subidx_found |=> alarm_r[ALM_SUBIDX])
        else $error("sub-index alarm missing");
    a_size_alarm: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && obj_found && subidx_found && msg_len != obj_len |=> alarm_r[ALM_SIZE])
        else $error("size alarm missing");
    a_size_masked: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && obj_found && !subidx_found && !alarm_r[ALM_SIZE] |=> !alarm_r[ALM_SIZE])
        else $error("size alarm on missing sub-index");
    a_rdonly_refuse: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && pdo_is_write && obj_found && obj_read_only
        |=> write_rej_r && !write_ok_r && alarm_r[ALM_RDONLY])
        else $error("read-only write not refused");
    a_rdonly_read: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && !pdo_is_write && !alarm_r[ALM_RDONLY] |=> !alarm_r[ALM_RDONLY])
        else $error("read-only alarm on a read");
    a_wr_needs_write: assert property (@(posedge sys_clk) disable iff (rst)
        !(pdo_rx && pdo_is_write) |=> !write_ok_r && !write_rej_r)
        else $error("write verdict without a write");
    a_wr_exclusive: assert property (@(posedge sys_clk) disable iff (rst)
        !(write_ok_r && write_rej_r))
        else $error("write both accepted and refused");
    a_nopdo_alarm: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && pdo_map_req && obj_found && !obj_pdo_ok |=> alarm_r[ALM_NOPDO])
        else $error("unsupported object alarm missing");
    a_runprot_refuse: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && pdo_is_write && obj_found && drive_enabled && obj_run_prot
        |=> write_rej_r && alarm_r[ALM_RUNPROT])
        else $error("run-protected write not refused");
    a_runprot_idle: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && !drive_enabled && !alarm_r[ALM_RUNPROT] |=> !alarm_r[ALM_RUNPROT])
        else $error("run-protect alarm while disabled");
    a_wr_clean_ok: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && pdo_is_write && obj_found && subidx_found && msg_len == obj_len && !obj_read_only
        && (!pdo_map_req || obj_pdo_ok) && !(drive_enabled && obj_run_prot)
        |=> write_ok_r && !write_rej_r)
        else $error("clean write not accepted");
    a_index_alarm: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && !obj_found |=> alarm_r[ALM_INDEX])
        else $error("index alarm missing");
    a_index_masks: assert property (@(posedge sys_clk) disable iff (rst)
        pdo_rx && !obj_found && !clear_req
        |=> alarm_r[ALM_RUNPROT:ALM_SUBIDX] == $past(alarm_r[ALM_RUNPROT:ALM_SUBIDX]))
        else $error("finer alarm on missing index");
    a_alarm_clear: assert property (@(posedge sys_clk) disable iff (rst)
        nmt_reset_node && !sdo_rx && !pdo_rx |=> alarm_r == '0 && !alarm_any_r)
        else $error("alarms not cleared");
    a_fault_clear: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl_wr && ctrl_index == CTRL_OBJ_INDEX && ctrl_data[FAULT_RESET_BIT] && !fr_prev_r
        && !sdo_rx && !pdo_rx |=> alarm_r == '0 && !alarm_any_r)
        else $error("fault reset did not clear");
    a_fault_level: assert property (@(posedge sys_clk) disable iff (rst)
        alarm_r[ALM_SIZE] && fr_prev_r && !nmt_reset_node |=> alarm_r[ALM_SIZE])
        else $error("held fault reset cleared again");
    a_alarm_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        alarm_r[ALM_SIZE] && !clear_req |=> alarm_r[ALM_SIZE])
        else $error("alarm dropped without clear");
    a_all_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        !clear_req |=> (alarm_r & $past(alarm_r)) == $past(alarm_r))
        else $error("an alarm dropped without clear");
    a_any_matches: assert property (@(posedge sys_clk) disable iff (rst)
        alarm_any_r == (|alarm_r))
        else $error("summary flag disagrees with alarms");

    c_sdo_ovf:  cover property (@(posedge sys_clk) disable iff (rst) $rose(alarm_r[ALM_SDO_OVF]));
    c_rej:      cover property (@(posedge sys_clk) disable iff (rst) write_rej_r);
    c_ok:       cover property (@(posedge sys_clk) disable iff (rst) write_ok_r);
    c_clear:    cover property (@(posedge sys_clk) disable iff (rst) alarm_any_r ##1 !alarm_any_r);
    c_fault:    cover property (@(posedge sys_clk) disable iff (rst) fr_bit && !fr_prev_r && alarm_any_r);
endmodule : coac_checker
`default_nettype wire

// ===== tb/coac_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// network master model: issues sdo/pdo frames and clears
// ============================================================
module coac_master_model
    import coac_pkg::*;
(
    input  wire logic         sys_clk, // system clock
    output logic              sdo_rx,  // sdo frame taken
    output logic              pdo_rx,  // pdo frame taken
    output logic [7:0]        attr,    // wr,map,found,sub,ro,pok,rp,en
    output logic [SIZE_W-1:0] mlen,    // bytes in frame
    output logic [SIZE_W-1:0] olen,    // defined object size
    output logic              nmt_rst, // node reset pulse
    output logic              cw_wr,   // control object write
    output logic [15:0]       cw_idx,  // index of that write
    output logic [15:0]       cw_dat   // controlword value
);
    initial begin
        {sdo_rx, pdo_rx, nmt_rst, cw_wr} = 4'h0;
        {attr, mlen, olen, cw_idx, cw_dat} = '0;
    end
    // qualifiers are inverted once the frame is gone so a stale value never looks valid
    task automatic pdo(input logic [7:0] f, input logic [SIZE_W-1:0] ml, input logic [SIZE_W-1:0] ol);
        @(negedge sys_clk);
        {pdo_rx, attr, mlen, olen} = {1'b1, f, ml, ol};
        @(negedge sys_clk);
        {pdo_rx, attr, mlen, olen} = {1'b0, ~f, ~ml, ~ol};
    endtask : pdo
    task automatic sdo();
        @(negedge sys_clk);
        sdo_rx = 1'b1;
        @(negedge sys_clk);
        sdo_rx = 1'b0;
    endtask : sdo
    task automatic nmt();
        @(negedge sys_clk);
        nmt_rst = 1'b1;
        @(negedge sys_clk);
        nmt_rst = 1'b0;
    endtask : nmt
    task automatic ctrl(input logic [15:0] i, input logic [15:0] d);
        @(negedge sys_clk);
        {cw_wr, cw_idx, cw_dat} = {1'b1, i, d};
        @(negedge sys_clk);
        {cw_wr, cw_idx, cw_dat} = {1'b0, ~i, ~d};
    endtask : ctrl
endmodule : coac_master_model
`default_nettype wire

// ===== tb/canopen_object_access_checker_bench.sv
`timescale 1ns/100ps
`default_nettype none
module canopen_object_access_checker_bench
    import coac_pkg::*;
;
    localparam int WIN = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sdo_rx, pdo_rx, nmt_rst, cw_wr, any, wok, wrej;
    logic [7:0] attr, alarm;
    logic [SIZE_W-1:0] mlen, olen;
    logic [15:0] cw_idx, cw_dat;
    int err_count = 0;
    int cmp_count = 0;
    always #4 sys_clk = ~sys_clk;
    coac_master_model coac_master_model_i (.sys_clk(sys_clk), .sdo_rx(sdo_rx), .pdo_rx(pdo_rx), .attr(attr),
        .mlen(mlen), .olen(olen), .nmt_rst(nmt_rst), .cw_wr(cw_wr), .cw_idx(cw_idx), .cw_dat(cw_dat));
    coac_checker #(.WIN_CYCLES(WIN)) coac_checker_i (.sys_clk(sys_clk), .rst(rst), .sdo_rx(sdo_rx),
        .pdo_rx(pdo_rx), .pdo_is_write(attr[7]), .pdo_map_req(attr[6]), .pdo_index(16'h2000),
        .obj_found(attr[5]), .subidx_found(attr[4]), .msg_len(mlen), .obj_len(olen), .obj_read_only(attr[3]),
        .obj_pdo_ok(attr[2]), .obj_run_prot(attr[1]), .drive_enabled(attr[0]), .nmt_reset_node(nmt_rst),
        .ctrl_wr(cw_wr), .ctrl_index(cw_idx), .ctrl_data(cw_dat), .alarm_r(alarm), .alarm_any_r(any),
        .write_ok_r(wok), .write_rej_r(wrej));
    // ============================================================
    // checks and helpers
    // ============================================================
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk_alm(input logic [7:0] e);
        cmp_count++;
        if ({any, alarm} !== {|e, e}) begin
            err_count++;
            $display("[ERR] t=%0t alarm got %h exp %h", $time, {any, alarm}, {|e, e});
        end
    endtask : chk_alm
    task automatic chk_wr(input logic ok, input logic rej);
        cmp_count++;
        if ({wok, wrej} !== {ok, rej}) begin
            err_count++;
            $display("[ERR] t=%0t write got %h exp %h", $time, {wok, wrej}, {ok, rej});
        end
    endtask : chk_wr
    // spacing keeps the pdo rate check out of the attribute tests
    task automatic pdo_g(input logic [7:0] f, input logic [SIZE_W-1:0] ml, input logic [SIZE_W-1:0] ol);
        repeat (WIN + 4) @(negedge sys_clk);
        coac_master_model_i.pdo(f, ml, ol);
    endtask : pdo_g
    // ============================================================
    // scenarios
    // ============================================================
    task automatic test_subidx();
        pdo_g(8'ha4, 3'd4, 3'd4);
        chk_wr(1'b0, 1'b1);
        chk_alm(8'h04);
        pdo_g(8'h94, 3'd4, 3'd4);
        chk_alm(8'h84);
        coac_master_model_i.nmt();
        chk_alm(8'h00);
        $display("test_subidx done");
    endtask : test_subidx
    task automatic test_size();
        pdo_g(8'hb4, 3'd4, 3'd2);
        chk_wr(1'b0, 1'b1);
        chk_alm(8'h08);
        coac_master_model_i.ctrl(CTRL_OBJ_INDEX, 16'h0000);
        chk_alm(8'h08);
        coac_master_model_i.ctrl(CTRL_OBJ_INDEX, 16'h0080);
        chk_alm(8'h00);
        $display("test_size done");
    endtask : test_size
    task automatic test_access();
        pdo_g(8'hbc, 3'd4, 3'd4);
        chk_wr(1'b0, 1'b1);
        chk_alm(8'h10);
        coac_master_model_i.nmt();
        pdo_g(8'h70, 3'd2, 3'd2);
        chk_alm(8'h20);
        coac_master_model_i.nmt();
        pdo_g(8'hb6, 3'd4, 3'd4);
        chk_wr(1'b1, 1'b0);
        chk_alm(8'h00);
        pdo_g(8'hb7, 3'd4, 3'd4);
        chk_wr(1'b0, 1'b1);
        chk_alm(8'h40);
        coac_master_model_i.nmt();
        $display("test_access done");
    endtask : test_access
    task automatic test_overflow();
        coac_master_model_i.sdo();
        coac_master_model_i.sdo();
        chk_alm(8'h01);
        coac_master_model_i.nmt();
        pdo_g(8'h34, 3'd2, 3'd2);
        coac_master_model_i.pdo(8'h34, 3'd2, 3'd2);
        chk_alm(8'h02);
        coac_master_model_i.nmt();
        repeat (WIN + 4) @(negedge sys_clk);
        coac_master_model_i.sdo();
        pdo_g(8'h34, 3'd2, 3'd2);
        coac_master_model_i.sdo();
        pdo_g(8'h34, 3'd2, 3'd2);
        chk_alm(8'h00);
        $display("test_overflow done");
    endtask : test_overflow
    // second arrival one cycle inside the window, then exactly at its end,
    // where it must open a fresh window of its own
    task automatic test_window();
        repeat (WIN + 4) @(negedge sys_clk);
        coac_master_model_i.sdo();
        repeat (WIN - 3) @(negedge sys_clk);
        coac_master_model_i.sdo();
        chk_alm(8'h01);
        coac_master_model_i.nmt();
        repeat (WIN + 4) @(negedge sys_clk);
        coac_master_model_i.sdo();
        repeat (WIN - 2) @(negedge sys_clk);
        coac_master_model_i.sdo();
        chk_alm(8'h00);
        coac_master_model_i.sdo();
        chk_alm(8'h01);
        coac_master_model_i.nmt();
        chk_alm(8'h00);
        $display("test_window done");
    endtask : test_window
    // fault reset acts on its rising edge only; an event in the clearing cycle survives
    task automatic test_clear_edges();
        pdo_g(8'hb4, 3'd4, 3'd2);
        chk_alm(8'h08);
        coac_master_model_i.ctrl(CTRL_OBJ_INDEX, 16'h0080);
        chk_alm(8'h08);
        coac_master_model_i.ctrl(16'h6041, 16'h0000);
        coac_master_model_i.ctrl(CTRL_OBJ_INDEX, 16'h0080);
        chk_alm(8'h08);
        repeat (WIN + 4) @(negedge sys_clk);
        fork
            coac_master_model_i.nmt();
            coac_master_model_i.pdo(8'ha4, 3'd4, 3'd4);
        join
        chk_wr(1'b0, 1'b1);
        chk_alm(8'h04);
        coac_master_model_i.ctrl(CTRL_OBJ_INDEX, 16'h0000);
        coac_master_model_i.ctrl(CTRL_OBJ_INDEX, 16'h0080);
        chk_alm(8'h00);
        $display("test_clear_edges done");
    endtask : test_clear_edges
    initial begin
        #(200_000);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        chk_alm(8'h00);
        chk_wr(1'b0, 1'b0);
        test_subidx();
        test_size();
        test_access();
        test_overflow();
        test_window();
        test_clear_edges();
        print_verdict();
    end
endmodule : canopen_object_access_checker_bench
`default_nettype wire
